/* File: rtl/sbr_rx_status.sv */
`timescale 1ns/1ps
module sbr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level.
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic do_wr;
    logic do_rd;

    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    assign in_ready = level != LW'(DEPTH);
    assign out_valid = level != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                level <= level + 1'b1;
            end else if (do_rd && !do_wr) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule : sbr_fifo

module sbr_rx_status
    import sbr_pkg::*;
#(
    parameter int DEPTH = 32,
    parameter int WAIT0_CYC = SBR_WAIT0_CYC,
    parameter int WAIT1_CYC = SBR_WAIT1_CYC
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Configuration.
    input wire logic [7:0] station_addr,
    input wire logic [7:0] group_addr,
    input wire logic multi_frame_option,
    input wire logic speed_mode,
    input wire logic slave_receive_set,
    // Frame events from the bus layer.
    input wire logic hdr_valid,
    input wire sbr_pkg::sbr_hdr_t hdr,
    input wire logic ctl_valid,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic frame_end,
    // Answers to the bus layer.
    output logic byte_nak,
    output logic status_bit1,
    // Host side of the receive FIFO.
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    // Status to host.
    output sbr_pkg::sbr_ret_t slave_return_code,
    output logic slave_receive_flag,
    output logic [7:0] second_receive_count
);
    import sbr_pkg::*;

    typedef enum logic [1:0] {
        SBR_IDLE = 2'b00,
        SBR_HEAD = 2'b01,
        SBR_DATA = 2'b10,
        SBR_WAIT = 2'b11
    } sbr_state_t;

    localparam int LW = $clog2(DEPTH + 1);
    sbr_state_t state;
    logic bcast;
    logic is_slave;
    logic is_bcast;
    logic buf_ready;
    logic armed;
    logic [1:0] hcnt;
    logic [7:0] want;
    logic [7:0] got;
    logic [7:0] held;
    logic [31:0] wait_cnt;
    logic in_valid;
    logic in_ready;
    logic [7:0] in_data;
    logic [LW-1:0] level;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic rd_pop;
    logic end_pend;

    assign is_slave = hdr.broadcast && hdr.slave_addr == station_addr;
    assign is_bcast = !hdr.broadcast &&
        (hdr.slave_addr == SBR_ALL_UNITS || hdr.slave_addr == group_addr);
    assign rd_pop = rd_valid && rd_ready;
    assign buf_ready = slave_receive_flag && (multi_frame_option ?
        (LW'(DEPTH) - level) >= LW'(SBR_MIN_FREE) : level == '0);

    always_comb begin
        in_valid = 1'b0;
        in_data = held;
        if (state == SBR_HEAD) begin
            in_valid = 1'b1;
            unique case (hcnt)
                2'd0: in_data = hdr.master_addr;
                2'd1: in_data = {4'h0, hdr.control};
                default: in_data = hdr.data_length;
            endcase
        end else if (state == SBR_WAIT) begin
            in_valid = 1'b1;
        end
    end

    sbr_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_data),
        .out_valid(fifo_valid),
        .out_ready(rd_pop),
        .out_data(fifo_data),
        .level(level)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            rd_valid <= fifo_valid && !rd_pop;
            rd_data <= fifo_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_bit1 <= 1'b1;
        end else if (ctl_valid &&
                     (hdr.control == SBR_CTL_STAT_A || hdr.control == SBR_CTL_STAT_B)) begin
            status_bit1 <= !buf_ready;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= SBR_IDLE;
            bcast <= 1'b0;
            armed <= 1'b0;
            hcnt <= 2'd0;
            want <= 8'h00;
            got <= 8'h00;
            held <= 8'h00;
            wait_cnt <= '0;
            end_pend <= 1'b0;
            byte_nak <= 1'b0;
            slave_return_code <= '0;
            slave_receive_flag <= 1'b0;
            second_receive_count <= 8'h00;
        end else begin
            slave_return_code.strobe <= 1'b0;
            byte_nak <= 1'b0;
            if (frame_end && state != SBR_IDLE && state != SBR_DATA) begin
                end_pend <= 1'b1;
            end
            if (ctl_valid) begin
                armed <= buf_ready && (is_slave || is_bcast);
            end
            unique case (state)
                SBR_IDLE: begin
                    if (hdr_valid && armed && (is_slave || is_bcast)) begin
                        state <= SBR_HEAD;
                        bcast <= is_bcast;
                        hcnt <= 2'd0;
                        got <= 8'h00;
                        want <= hdr.data_length;
                        armed <= 1'b0;
                        slave_return_code <= '{code: is_bcast ? SBR_RC_BC_START
                                                              : SBR_RC_SL_START,
                                               strobe: 1'b1};
                    end
                end
                SBR_HEAD: begin
                    hcnt <= hcnt + 2'd1;
                    if (hcnt == 2'd2) begin
                        state <= SBR_DATA;
                    end
                end
                SBR_DATA: begin
                    if (frame_end || end_pend || got == want) begin
                        state <= SBR_IDLE;
                        end_pend <= 1'b0;
                        slave_receive_flag <= 1'b0;
                        second_receive_count <= got;
                        slave_return_code <= '{code: got == want
                            ? (bcast ? SBR_RC_BC_DONE : SBR_RC_SL_DONE)
                            : (bcast ? SBR_RC_BC_ABORT : SBR_RC_SL_ABORT), strobe: 1'b1};
                    end else if (byte_valid) begin
                        held <= byte_data;
                        state <= SBR_WAIT;
                        wait_cnt <= speed_mode ? WAIT1_CYC : WAIT0_CYC;
                        if (!in_ready) begin
                            slave_return_code <= '{code: bcast ? SBR_RC_BC_FULL
                                                               : SBR_RC_SL_FULL,
                                                   strobe: 1'b1};
                        end
                    end
                end
                SBR_WAIT: begin
                    if (in_ready) begin
                        got <= got + 8'd1;
                        state <= SBR_DATA;
                    end else if (wait_cnt == 0) begin
                        byte_nak <= 1'b1;
                        state <= SBR_DATA;
                    end else if (frame_end) begin
                        state <= SBR_DATA;
                    end else begin
                        wait_cnt <= wait_cnt - 1;
                    end
                end
            endcase
            if (slave_receive_set) begin
                slave_receive_flag <= 1'b1;
            end
        end
    end

    sequence s_head_bytes;
        in_valid && in_ready && in_data == $past(hdr.master_addr)
        ##1 in_valid && in_ready && in_data == {4'h0, $past(hdr.control, 2)}
        ##1 in_valid && in_ready && in_data == $past(hdr.data_length, 3);
    endsequence

    chk_start_code: assert property (@(posedge clock) disable iff (rst)
        state == SBR_IDLE && $past(state) == SBR_IDLE && hdr_valid && armed && is_slave
        |=> slave_return_code.strobe && slave_return_code.code == SBR_RC_SL_START)
        else $error("directed start code missing");
    chk_bc_start: assert property (@(posedge clock) disable iff (rst)
        state == SBR_IDLE && hdr_valid && armed && is_bcast
        |=> slave_return_code.strobe && slave_return_code.code == SBR_RC_BC_START)
        else $error("broadcast start code missing");
    chk_no_start: assert property (@(posedge clock) disable iff (rst)
        ctl_valid && !buf_ready |=> !armed)
        else $error("start armed without ready buffer");
    chk_end_flag: assert property (@(posedge clock) disable iff (rst)
        state == SBR_DATA && (frame_end || end_pend || got == want) && !slave_receive_set
        |=> !slave_receive_flag && second_receive_count == $past(got))
        else $error("end did not clear flag");
    chk_head_write: assert property (@(posedge clock) disable iff (rst)
        state == SBR_IDLE && hdr_valid && armed && (is_slave || is_bcast) |=> s_head_bytes)
        else $error("header bytes not written");
    chk_full_code: assert property (@(posedge clock) disable iff (rst)
        state == SBR_DATA && !(frame_end || end_pend || got == want) && byte_valid && !in_ready
        |=> slave_return_code.strobe &&
            slave_return_code.code == ($past(bcast) ? SBR_RC_BC_FULL : SBR_RC_SL_FULL))
        else $error("full code missing");
    chk_nak_timeout: assert property (@(posedge clock) disable iff (rst)
        state == SBR_WAIT && !in_ready && wait_cnt == 0 |=> byte_nak)
        else $error("timed out byte not refused");
endmodule : sbr_rx_status

/* File: rtl/sbr_pkg.sv */
package sbr_pkg;
    localparam logic [3:0] SBR_RC_SL_START = 4'h4;
    localparam logic [3:0] SBR_RC_SL_FULL = 4'h5;
    localparam logic [3:0] SBR_RC_SL_DONE = 4'h6;
    localparam logic [3:0] SBR_RC_SL_ABORT = 4'h7;
    localparam logic [3:0] SBR_RC_BC_START = 4'h8;
    localparam logic [3:0] SBR_RC_BC_FULL = 4'h9;
    localparam logic [3:0] SBR_RC_BC_DONE = 4'ha;
    localparam logic [3:0] SBR_RC_BC_ABORT = 4'hb;
    localparam logic [7:0] SBR_ALL_UNITS = 8'hff;
    localparam logic [3:0] SBR_CTL_STAT_A = 4'h0;
    localparam logic [3:0] SBR_CTL_STAT_B = 4'h6;
    localparam int SBR_MIN_FREE = 4;
    localparam int SBR_CLK_MHZ = 125;
    localparam int SBR_WAIT0_US = 1570;
    localparam int SBR_WAIT1_US = 390;
    localparam int SBR_WAIT0_CYC = SBR_WAIT0_US * SBR_CLK_MHZ;
    localparam int SBR_WAIT1_CYC = SBR_WAIT1_US * SBR_CLK_MHZ;

    typedef struct packed {
        logic broadcast;
        logic [7:0] master_addr;
        logic [7:0] slave_addr;
        logic [3:0] control;
        logic [7:0] data_length;
    } sbr_hdr_t;

    typedef struct packed {
        logic [3:0] code;
        logic strobe;
    } sbr_ret_t;
endpackage : sbr_pkg

/* File: dv/sbr_master_model.sv */
`timescale 1ns/1ps
module sbr_master_model
    import sbr_pkg::*;
(
    // Clock.
    input wire logic clock,
    // Frame events towards the receiver.
    output logic ctl_valid,
    output logic hdr_valid,
    output sbr_pkg::sbr_hdr_t hdr,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic frame_end
);
    initial begin
        ctl_valid = 1'b0;
        hdr_valid = 1'b0;
        hdr = '0;
        byte_valid = 1'b0;
        byte_data = 8'h00;
        frame_end = 1'b0;
    end

    // Ends the frame; the header lines no longer hold their value.
    task finish;
        @(posedge clock);
        frame_end <= 1'b1;
        @(posedge clock);
        frame_end <= 1'b0;
        hdr <= ~hdr;
    endtask : finish

    // Sends control, header one cycle later, then nb data bytes two cycles apart.
    task frame(input logic bc, input logic [7:0] sa, input logic [3:0] ctl,
               input logic [7:0] len, input int nb, input logic fin);
        int i;
        @(posedge clock);
        hdr <= {bc, 8'h3c, sa, ctl, len};
        ctl_valid <= 1'b1;
        @(posedge clock);
        ctl_valid <= 1'b0;
        hdr_valid <= 1'b1;
        @(posedge clock);
        hdr_valid <= 1'b0;
        repeat (4) @(posedge clock);
        for (i = 0; i < nb; i++) begin
            byte_valid <= 1'b1;
            byte_data <= 8'h10 + i[7:0];
            @(posedge clock);
            byte_valid <= 1'b0;
            byte_data <= ~(8'h10 + i[7:0]);
            @(posedge clock);
        end
        if (fin) begin
            finish();
        end
    endtask : frame
endmodule : sbr_master_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
    import sbr_pkg::*;
    logic clock, rst, opt, speed, arm_p, rd_ready, byte_nak, status_bit1, rd_valid, flag, sb1;
    logic ctl_valid, hdr_valid, byte_valid, frame_end, ctl_d;
    logic [7:0] byte_data, rd_data, count;
    logic [3:0] codes [32];
    sbr_hdr_t hdr;
    sbr_ret_t ret;
    int miscompares = 0, n_compared = 0, n_strobe = 0, n_nak = 0, cycles = 0, b;

    sbr_master_model m (.clock(clock), .ctl_valid(ctl_valid), .hdr_valid(hdr_valid), .hdr(hdr),
        .byte_valid(byte_valid), .byte_data(byte_data), .frame_end(frame_end));
    sbr_rx_status #(.DEPTH(32), .WAIT0_CYC(20), .WAIT1_CYC(12)) dut (.clock(clock), .rst(rst),
        .station_addr(8'h21), .group_addr(8'h40), .multi_frame_option(opt),
        .speed_mode(speed), .slave_receive_set(arm_p), .hdr_valid(hdr_valid), .hdr(hdr),
        .ctl_valid(ctl_valid), .byte_valid(byte_valid), .byte_data(byte_data),
        .frame_end(frame_end), .byte_nak(byte_nak), .status_bit1(status_bit1),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .slave_return_code(ret),
        .slave_receive_flag(flag), .second_receive_count(count));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Records return codes, dropped bytes and the status bit after each control field.
    always @(posedge clock) begin
        ctl_d <= ctl_valid;
        if (ctl_d) sb1 <= status_bit1;
        if (ret.strobe === 1'b1) begin
            codes[n_strobe[4:0]] <= ret.code;
            n_strobe <= n_strobe + 1;
        end
        if (byte_nak === 1'b1) n_nak <= n_nak + 1;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            conclude();
        end
    end

    task conclude;
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task arm;
        @(posedge clock);
        arm_p <= 1'b1;
        @(posedge clock);
        arm_p <= 1'b0;
    endtask : arm

    task pop(input logic [7:0] e);
        int i;
        for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(negedge clock);
        check(rd_data, e);
        @(posedge clock);
        rd_ready <= 1'b1;
        @(posedge clock);
        rd_ready <= 1'b0;
        repeat (2) @(negedge clock);
    endtask : pop

    task run(input logic bc, input logic [7:0] sa, input logic [3:0] ctl, input logic [7:0] len,
             input int nb, input logic [3:0] c0, input logic [3:0] c1);
        int i;
        arm();
        b = n_strobe;
        m.frame(bc, sa, ctl, len, nb, 1'b1);
        repeat (3) @(negedge clock);
        check(codes[b], c0);
        check(codes[b+1], c1);
        check(flag, 1'b0);
        check(count, nb);
        pop(8'h3c);
        pop({4'h0, ctl});
        pop(len);
        for (i = 0; i < nb; i++) pop(8'h10 + i[7:0]);
    endtask : run

    initial begin
        rst = 1'b1;
        opt = 1'b0;
        speed = 1'b0;
        arm_p = 1'b0;
        rd_ready = 1'b0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check(status_bit1, 1'b1);
        check(flag, 1'b0);
        m.frame(1'b1, 8'h21, 4'h6, 8'h02, 2, 1'b1);
        repeat (3) @(negedge clock);
        check(n_strobe, 0);
        check(rd_valid, 1'b0);
        check(sb1, 1'b1);
        arm();
        m.frame(1'b1, 8'h22, 4'h6, 8'h02, 2, 1'b1);
        m.frame(1'b0, 8'h21, 4'h6, 8'h02, 2, 1'b1);
        repeat (3) @(negedge clock);
        check(n_strobe, 0);
        check(rd_valid, 1'b0);
        run(1'b1, 8'h21, 4'h6, 8'h02, 2, 4'h4, 4'h6);
        check(sb1, 1'b0);
        run(1'b1, 8'h21, 4'h0, 8'h03, 1, 4'h4, 4'h7);
        run(1'b0, 8'hff, 4'h1, 8'h01, 1, 4'h8, 4'ha);
        run(1'b0, 8'h40, 4'h2, 8'h02, 0, 4'h8, 4'hb);
        @(posedge clock);
        opt <= 1'b1;
        speed <= 1'b1;
        arm();
        b = n_strobe;
        m.frame(1'b1, 8'h21, 4'h6, 8'd40, 30, 1'b0);
        repeat (16) @(negedge clock);
        check(codes[b+1], 4'h5);
        check(n_nak, 1);
        m.finish();
        repeat (3) @(negedge clock);
        check(codes[b+2], 4'h7);
        check(count, 8'd29);
        conclude();
    end
endmodule : tb
